// ==== pcm_pkg.sv ====
package pcm_pkg;

	// ----------------------------------------------------------------
	// Register map (index = printed offset, byte address = 4 * index)
	// ----------------------------------------------------------------
	localparam int PCM_ADDR_W = 10;
	localparam logic [7:0] PCM_POWER_CONTROL_IDX = 8'h87;
	localparam logic [7:0] PCM_EXT_FLAG_CLOCK_SELECT_IDX = 8'h91;
	localparam logic [7:0] PCM_POWER_MGMT_IDX = 8'hC4;
	localparam logic [7:0] PCM_ACTIVITY_STATUS_IDX = 8'hC5;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int PCM_PC_IDLE_BIT = 0;
	localparam int PCM_PC_STOP_BIT = 1;
	localparam int PCM_EX_CLOCK_SOURCE_SELECT_BIT = 3;
	localparam int PCM_EX_RING_ACTIVE_FLAG_BIT = 2;
	localparam int PCM_EX_RING_START_SELECT_BIT = 1;
	localparam int PCM_EX_BANDGAP_KEEP_ON_BIT = 0;
	localparam int PCM_PM_CYCLE_DIV_HI_BIT = 7;
	localparam int PCM_PM_CYCLE_DIV_LO_BIT = 6;
	localparam int PCM_PM_AUTO_SPEEDUP_ENABLE_BIT = 5;
	localparam int PCM_PM_CRYSTAL_DISABLE_BIT = 3;
	localparam int PCM_ST_POWERFAIL_LEVEL_BIT = 7;
	localparam int PCM_ST_HIGH_LEVEL_BIT = 6;
	localparam int PCM_ST_LOW_LEVEL_BIT = 5;
	localparam int PCM_ST_CRYSTAL_READY_BIT = 4;
	localparam int PCM_ST_SERIAL0_TX_BIT = 1;
	localparam int PCM_ST_SERIAL0_RX_BIT = 0;

	// ----------------------------------------------------------------
	// Divider codes and clocks per instruction cycle
	// ----------------------------------------------------------------
	localparam logic [1:0] PCM_DIV_RESERVED = 2'h0;
	localparam logic [1:0] PCM_DIV_4 = 2'h1;
	localparam logic [1:0] PCM_DIV_64 = 2'h2;
	localparam logic [1:0] PCM_DIV_1024 = 2'h3;
	localparam logic [10:0] PCM_CLKS_DIV_4 = 11'h004;
	localparam logic [10:0] PCM_CLKS_DIV_64 = 11'h040;
	localparam logic [10:0] PCM_CLKS_DIV_1024 = 11'h400;

	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic PCM_CLOCK_SOURCE_SELECT_RST = 1'b1;
	localparam logic PCM_CRYSTAL_READY_RST = 1'b1;
	localparam logic [7:0] PCM_POWER_CONTROL_RST = 8'h00;
	localparam int PCM_WARMUP_XTAL_CLKS = 65536;

	// ----------------------------------------------------------------
	// Carriers and states
	// ----------------------------------------------------------------
	typedef struct packed {
		logic powerfail_in_service;
		logic high_in_service;
		logic low_in_service;
		logic serial0_tx_active;
		logic serial0_rx_active;
	} pcm_core_stat_t;

	typedef struct packed {
		logic any_irq;
		logic ext_irq;
		logic ext_irq_serviceable;
		logic serial_start_bit;
		logic serial_rx_enable;
		logic powerfail_irq;
		logic powerfail_rst;
	} pcm_wake_t;

	typedef enum logic [3:0] {
		PCM_S_RUN = 4'b0001,
		PCM_S_IDLE = 4'b0010,
		PCM_S_STOP = 4'b0100,
		PCM_S_WARM = 4'b1000
	} pcm_state_t;

endpackage

// ==== pcm_warmup_counter.sv ====
`timescale 1ns/1ps
`default_nettype none

module pcm_warmup_counter
	import pcm_pkg::*;
#(
	parameter int COUNT = 65536,
	parameter bit DONE_AT_RESET = 1'b1
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic restart,
	input wire logic tick,
	// Result
	output logic done
);

	localparam int W = $clog2(COUNT + 1);

	logic [W-1:0] cnt_reg;
	logic done_reg;

	// Count ticks; held cleared while restart stands
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_reg <= '0;
			done_reg <= DONE_AT_RESET;
		end
		else if (restart)
		begin
			cnt_reg <= '0;
			done_reg <= 1'b0;
		end
		else if (tick && !done_reg)
		begin
			if (cnt_reg == W'(COUNT - 1))
				done_reg <= 1'b1;
			cnt_reg <= cnt_reg + W'(1);
		end
	end

	assign done = done_reg;

endmodule

`default_nettype wire

// ==== pcm_power_clock_manager.sv ====
//
// Behaviour
// - Divider field: 01 four clocks, 10 sixty-four, 11 1024; resets to 01.
// - Slow divider codes accepted only while the field holds 01.
// - Source select 1 crystal, 0 ring; 0->1 needs crystal ready and enabled.
// - Ring flag reads 1 while CPU runs from ring; resets 0.
// - With auto speedup enabled, switchback events restore divide by four.
// - Crystal disable stops amplifier; setting only allowed while ring selected.
// - Three status bits show power-fail, high, low level in service.
// - Crystal ready flag shows stable oscillation; resets to 1.
// - Serial 0 transmit and receive activity flags; reset 0.
// - Power control bit 0 enters IDLE; peripherals run, CPU halts.
// - IDLE ends on any interrupt or reset.
// - Power control bit 1 enters STOP, halting all clocks and crystal.
// - STOP ends only on external interrupt, reset, or power-fail interrupt with band-gap kept on.
// - Band-gap keep-on bit keeps reference on in STOP only.
// - With band-gap kept on, power-fail interrupt and reset end STOP.
// - STOP with band-gap off drives supply reset output low.
// - Ring start select runs CPU from ring right after STOP wake.
// - After ring wake, switch to crystal after 65536 crystal clocks.
// - New divider applies one instruction cycle later, to all functions.
// - Switchback on serviceable external interrupt or enabled serial start bit.
// - Slow divider writes blocked while any serial activity flag is set.
// - Crystal ready set 65536 crystal clocks after crystal disable clears.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module pcm_power_clock_manager
	import pcm_pkg::*;
#(
	parameter int WARMUP_CLKS = PCM_WARMUP_XTAL_CLKS
)
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [PCM_ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Core status and wake sources
	input wire pcm_core_stat_t CORE_STAT,
	input wire pcm_wake_t WAKE,
	// One pulse per crystal oscillator clock
	input wire logic XTAL_TICK,
	// Clock control outputs
	output logic CYCLE_STB,
	output logic [1:0] CYCLE_DIV,
	output logic CPU_RUN,
	output logic CLOCKS_ON,
	output logic USE_RING,
	output logic XTAL_AMP_EN,
	// Power outputs
	output logic BANDGAP_ON,
	output logic SUPPLY_RESET_OUT_N,
	output logic PF_RESET_REQ
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	pcm_state_t state_reg;
	pcm_state_t state_next;
	logic [7:0] power_control_reg;
	logic [1:0] cycle_div_reg;
	logic [1:0] cycle_div_eff_reg;
	logic auto_speedup_enable_reg;
	logic crystal_disable_reg;
	logic clock_source_select_reg;
	logic ring_start_select_reg;
	logic bandgap_keep_on_reg;
	logic ring_forced_reg;
	pcm_core_stat_t stat_reg;
	logic [10:0] cyc_cnt_reg;
	logic [10:0] cyc_len;
	logic cycle_stb_reg;
	logic pf_reset_reg;
	logic crystal_ready;
	logic amp_en;
	logic stop_wake;
	logic switchback;
	logic serial_busy;
	logic wr_en;
	logic [7:0] reg_idx;
	logic hit_pc;
	logic hit_ex;
	logic hit_pm;
	logic hit_st;
	logic [1:0] wr_div;
	logic [7:0] rd_byte;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	// Word addressed: index sits above the two byte bits
	assign reg_idx = PADDR[PCM_ADDR_W-1:2];
	assign hit_pc = (reg_idx == PCM_POWER_CONTROL_IDX);
	assign hit_ex = (reg_idx == PCM_EXT_FLAG_CLOCK_SELECT_IDX);
	assign hit_pm = (reg_idx == PCM_POWER_MGMT_IDX);
	assign hit_st = (reg_idx == PCM_ACTIVITY_STATUS_IDX);
	assign wr_en = PSEL && PENABLE && PWRITE;
	assign wr_div = PWDATA[PCM_PM_CYCLE_DIV_HI_BIT:PCM_PM_CYCLE_DIV_LO_BIT];

	// Zero wait states; unmapped addresses answer with an error
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !(hit_pc || hit_ex || hit_pm || hit_st);

	// ----------------------------------------------------------------
	// Status sampling
	// ----------------------------------------------------------------
	// Status inputs are registered so reads show a stable copy
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			stat_reg <= '0;
		else
			stat_reg <= CORE_STAT;
	end

	assign serial_busy = stat_reg.serial0_tx_active || stat_reg.serial0_rx_active;

	assign switchback = auto_speedup_enable_reg &&
		(WAKE.ext_irq_serviceable || (WAKE.serial_start_bit && WAKE.serial_rx_enable));

	// ----------------------------------------------------------------
	// Cycle divider field
	// ----------------------------------------------------------------
	// Hardware switchback wins over a software write in the same cycle
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			cycle_div_reg <= PCM_DIV_4;
		else if (switchback)
			cycle_div_reg <= PCM_DIV_4;
		else if (wr_en && hit_pm)
		begin
			if (wr_div == PCM_DIV_4)
				cycle_div_reg <= PCM_DIV_4;
			else if (wr_div != PCM_DIV_RESERVED && cycle_div_reg == PCM_DIV_4 && !serial_busy)
				cycle_div_reg <= wr_div;
		end
	end

	// ----------------------------------------------------------------
	// Other power management bits
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			auto_speedup_enable_reg <= 1'b0;
			crystal_disable_reg <= 1'b0;
		end
		else if (wr_en && hit_pm)
		begin
			auto_speedup_enable_reg <= PWDATA[PCM_PM_AUTO_SPEEDUP_ENABLE_BIT];
			if (!PWDATA[PCM_PM_CRYSTAL_DISABLE_BIT] || !clock_source_select_reg)
				crystal_disable_reg <= PWDATA[PCM_PM_CRYSTAL_DISABLE_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Clock source and STOP options
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			clock_source_select_reg <= PCM_CLOCK_SOURCE_SELECT_RST;
			ring_start_select_reg <= 1'b0;
			bandgap_keep_on_reg <= 1'b0;
		end
		else if (wr_en && hit_ex)
		begin
			// crystal only when ready and enabled
			if (!PWDATA[PCM_EX_CLOCK_SOURCE_SELECT_BIT] || clock_source_select_reg ||
				(crystal_ready && !crystal_disable_reg))
				clock_source_select_reg <= PWDATA[PCM_EX_CLOCK_SOURCE_SELECT_BIT];
			ring_start_select_reg <= PWDATA[PCM_EX_RING_START_SELECT_BIT];
			bandgap_keep_on_reg <= PWDATA[PCM_EX_BANDGAP_KEEP_ON_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Crystal warm-up
	// ----------------------------------------------------------------
	// amplifier off when disabled or in STOP
	assign amp_en = !crystal_disable_reg && (state_reg != PCM_S_STOP);

	pcm_warmup_counter #(
		.COUNT(WARMUP_CLKS),
		.DONE_AT_RESET(PCM_CRYSTAL_READY_RST)
	) u_warmup (
		.clk(CLK),
		.rst_n(RST_N),
		.restart(!amp_en),
		.tick(XTAL_TICK),
		.done(crystal_ready)
	);

	// Ring stands in after a ring wake until the crystal is stable
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			ring_forced_reg <= 1'b0;
		else if (state_reg == PCM_S_STOP && stop_wake && ring_start_select_reg)
			ring_forced_reg <= 1'b1;
		else if (crystal_ready)
			ring_forced_reg <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Power control register
	// ----------------------------------------------------------------
	// Mode bits clear themselves when the mode ends; a write in that
	// same cycle wins so a request is never lost
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			power_control_reg <= PCM_POWER_CONTROL_RST;
		else if (wr_en && hit_pc)
			power_control_reg <= PWDATA[7:0];
		else if ((state_reg == PCM_S_IDLE || state_reg == PCM_S_STOP) &&
			state_next != state_reg)
		begin
			power_control_reg[PCM_PC_IDLE_BIT] <= 1'b0;
			power_control_reg[PCM_PC_STOP_BIT] <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Mode state machine
	// ----------------------------------------------------------------
	// STOP wake sources
	assign stop_wake = WAKE.ext_irq || (bandgap_keep_on_reg && WAKE.powerfail_irq);

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			PCM_S_RUN:
			begin
				if (power_control_reg[PCM_PC_STOP_BIT])
					state_next = PCM_S_STOP;
				else if (power_control_reg[PCM_PC_IDLE_BIT])
					state_next = PCM_S_IDLE;
			end
			PCM_S_IDLE:
			begin
				if (WAKE.any_irq)
					state_next = PCM_S_RUN;
			end
			PCM_S_STOP:
			begin
				if (stop_wake && (ring_start_select_reg || !clock_source_select_reg))
					state_next = PCM_S_RUN;
				else if (stop_wake)
					state_next = PCM_S_WARM;
			end
			PCM_S_WARM:
			begin
				if (crystal_ready)
					state_next = PCM_S_RUN;
			end
			default:
				state_next = PCM_S_RUN;
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			state_reg <= PCM_S_RUN;
		else
			state_reg <= state_next;
	end

	// Power-fail reset is only sensed while the reference is powered
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			pf_reset_reg <= 1'b0;
		else
			pf_reset_reg <= WAKE.powerfail_rst &&
				(state_reg != PCM_S_STOP || bandgap_keep_on_reg);
	end

	// ----------------------------------------------------------------
	// Instruction cycle prescaler
	// ----------------------------------------------------------------
	always_comb
	begin
		case (cycle_div_eff_reg)
			PCM_DIV_64: cyc_len = PCM_CLKS_DIV_64;
			PCM_DIV_1024: cyc_len = PCM_CLKS_DIV_1024;
			default: cyc_len = PCM_CLKS_DIV_4;
		endcase
	end

	// Counter freezes while clocks are stopped so no cycle is issued
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			cyc_cnt_reg <= '0;
			cycle_stb_reg <= 1'b0;
			cycle_div_eff_reg <= PCM_DIV_4;
		end
		// Also frozen on the entry edge, so no strobe escapes into STOP
		else if (state_reg == PCM_S_STOP || state_reg == PCM_S_WARM ||
			state_next == PCM_S_STOP)
			cycle_stb_reg <= 1'b0;
		else if (cyc_cnt_reg == cyc_len - 11'h001)
		begin
			cyc_cnt_reg <= '0;
			cycle_stb_reg <= 1'b1;
			cycle_div_eff_reg <= cycle_div_reg;
		end
		else
		begin
			cyc_cnt_reg <= cyc_cnt_reg + 11'h001;
			cycle_stb_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	always_comb
	begin
		rd_byte = 8'h00;
		if (hit_pc)
			rd_byte = power_control_reg;
		else if (hit_ex)
		begin
			rd_byte[PCM_EX_CLOCK_SOURCE_SELECT_BIT] = clock_source_select_reg;
			rd_byte[PCM_EX_RING_ACTIVE_FLAG_BIT] = USE_RING;
			rd_byte[PCM_EX_RING_START_SELECT_BIT] = ring_start_select_reg;
			rd_byte[PCM_EX_BANDGAP_KEEP_ON_BIT] = bandgap_keep_on_reg;
		end
		else if (hit_pm)
		begin
			rd_byte[PCM_PM_CYCLE_DIV_HI_BIT:PCM_PM_CYCLE_DIV_LO_BIT] = cycle_div_reg;
			rd_byte[PCM_PM_AUTO_SPEEDUP_ENABLE_BIT] = auto_speedup_enable_reg;
			rd_byte[PCM_PM_CRYSTAL_DISABLE_BIT] = crystal_disable_reg;
		end
		else if (hit_st)
		begin
			rd_byte[PCM_ST_POWERFAIL_LEVEL_BIT] = stat_reg.powerfail_in_service;
			rd_byte[PCM_ST_HIGH_LEVEL_BIT] = stat_reg.high_in_service;
			rd_byte[PCM_ST_LOW_LEVEL_BIT] = stat_reg.low_in_service;
			rd_byte[PCM_ST_CRYSTAL_READY_BIT] = crystal_ready;
			rd_byte[PCM_ST_SERIAL0_TX_BIT] = stat_reg.serial0_tx_active;
			rd_byte[PCM_ST_SERIAL0_RX_BIT] = stat_reg.serial0_rx_active;
		end
	end

	assign PRDATA = (PSEL && !PWRITE) ? {24'h000000, rd_byte} : 32'h00000000;

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign CYCLE_STB = cycle_stb_reg;
	assign CYCLE_DIV = cycle_div_eff_reg;
	// CPU halted in IDLE, STOP and warm-up
	assign CPU_RUN = (state_reg == PCM_S_RUN);
	assign CLOCKS_ON = (state_reg == PCM_S_RUN || state_reg == PCM_S_IDLE);
	assign USE_RING = !clock_source_select_reg || ring_forced_reg;
	assign XTAL_AMP_EN = amp_en;
	assign BANDGAP_ON = (state_reg != PCM_S_STOP) || bandgap_keep_on_reg;
	// supply reset low in bare STOP
	assign SUPPLY_RESET_OUT_N = !(state_reg == PCM_S_STOP && !bandgap_keep_on_reg);
	assign PF_RESET_REQ = pf_reset_reg;

endmodule

`default_nettype wire

// ==== pcm_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none

module pcm_asserts
	import pcm_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Observed ports
	input wire pcm_wake_t WAKE,
	input wire logic CYCLE_STB,
	input wire logic [1:0] CYCLE_DIV,
	input wire logic CPU_RUN,
	input wire logic CLOCKS_ON,
	input wire logic XTAL_AMP_EN,
	input wire logic BANDGAP_ON,
	input wire logic SUPPLY_RESET_OUT_N
);
	// One clock domain, so clocking and reset are given once
	default clocking dc @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	a_div_legal: assert property (CYCLE_DIV != PCM_DIV_RESERVED)
		else $error("divider holds reserved code");
	a_div_at_stb: assert property (!CYCLE_STB |-> $stable(CYCLE_DIV))
		else $error("divider changed between cycle boundaries");
	a_stb_spacing: assert property (CYCLE_STB |=> !CYCLE_STB [*3])
		else $error("cycle strobes closer than four clocks");
	a_stb_frozen: assert property (!CLOCKS_ON |-> !CYCLE_STB)
		else $error("cycle strobe while clocks are off");
	a_stop_supply: assert property (!SUPPLY_RESET_OUT_N |->
		!BANDGAP_ON && !CLOCKS_ON && !XTAL_AMP_EN)
		else $error("supply reset low outside stop");
	a_bandgap_run: assert property (CLOCKS_ON |-> BANDGAP_ON && SUPPLY_RESET_OUT_N)
		else $error("band-gap off while clocks run");
	a_idle_wake: assert property (CLOCKS_ON && !CPU_RUN && WAKE.any_irq |=> CPU_RUN)
		else $error("idle not left on interrupt");
	a_stop_hold: assert property (!CLOCKS_ON && !XTAL_AMP_EN && !WAKE.ext_irq
		&& !WAKE.powerfail_irq |=> !CLOCKS_ON)
		else $error("stop left without a wake source");
endmodule

`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb
	import pcm_pkg::*;
;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam int WU = 16;
	localparam int TMO = 20000;
	localparam logic [7:0] PC = PCM_POWER_CONTROL_IDX;
	localparam logic [7:0] EX = PCM_EXT_FLAG_CLOCK_SELECT_IDX;
	localparam logic [7:0] PM = PCM_POWER_MGMT_IDX;
	localparam logic [7:0] ST = PCM_ACTIVITY_STATUS_IDX;
	logic clk, rst_n, psel, penable, pwrite, xtick, pready, pslverr, err, stb;
	logic cpu_run, clocks_on, use_ring, amp_en, bg_on, sup_n, pf_req;
	logic [PCM_ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] cdiv;
	pcm_core_stat_t cstat;
	pcm_wake_t wake;
	int err_count, check_count, cyc, t0;
	// Divider writes and the field expected after each
	logic [7:0] dw [6] = '{8'h80, 8'hC0, 8'h40, 8'hC0, 8'h00, 8'h40};
	logic [7:0] de [6] = '{8'h80, 8'h80, 8'h40, 8'hC0, 8'hC0, 8'h40};

	pcm_power_clock_manager #(.WARMUP_CLKS(WU)) dut_u (
		.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .CORE_STAT(cstat), .WAKE(wake), .XTAL_TICK(xtick),
		.CYCLE_STB(stb), .CYCLE_DIV(cdiv), .CPU_RUN(cpu_run), .CLOCKS_ON(clocks_on),
		.USE_RING(use_ring), .XTAL_AMP_EN(amp_en), .BANDGAP_ON(bg_on),
		.SUPPLY_RESET_OUT_N(sup_n), .PF_RESET_REQ(pf_req));

	// ------------------------------------------------------------
	// Clock, crystal ticks and timeout
	// ------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Crystal ticks every other cycle, so warm-up spans 2*WU cycles
	always @(posedge clk)
	begin
		xtick <= ~xtick;
		cyc <= cyc + 1;
		if (cyc == TMO)
		begin
			$display("ERROR timeout at %0t", $time);
			err_count = err_count + 1;
			print_verdict();
		end
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
			$display("ERROR at %0t got %0h exp %0h", $time, got, exp);
		if (got !== exp)
			err_count++;
	endtask

	// Request held until the edge where pready is high; data taken at that edge
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask

	task automatic rdchk(input logic [7:0] idx, input logic [7:0] e);
		apb(1'b0, idx, 8'h00);
		chk(rd, {24'h000000, e});
	endtask

	// Wake source held across exactly one sampling edge
	task automatic pulse(input pcm_wake_t w);
		@(posedge clk);
		wake <= w;
		@(posedge clk);
		wake <= '0;
		@(negedge clk);
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic wait_stb();
		int i;
		i = 0;
		do
		begin
			@(negedge clk);
			i++;
		end
		while (stb !== 1'b1 && i < 1100);
		@(negedge clk);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		cstat = '0;
		wake = '0;
		xtick = 1'b0;
		err_count = 0;
		check_count = 0;
		cyc = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rdchk(PC, 8'h00);
		rdchk(EX, 8'h08);
		rdchk(PM, 8'h40);
		rdchk(ST, 8'h10);
		apb(1'b0, 8'h00, 8'h00);
		chk(err, 1'b1);
		$display("test reset done");
		cstat <= 5'h1F;
		rdchk(ST, 8'hF3);
		cstat <= 5'h02;
		wr(PM, 8'h80);
		rdchk(PM, 8'h40);
		cstat <= 5'h00;
		for (int i = 0; i < 6; i++)
		begin
			wr(PM, dw[i]);
			rdchk(PM, de[i]);
			wait_stb();
			wait_stb();
			chk(cdiv, de[i][7:6]);
		end
		$display("test divider done");
		wr(PM, 8'hA0);
		pulse(7'h10);
		rdchk(PM, 8'h60);
		wr(PM, 8'h80);
		pulse(7'h10);
		rdchk(PM, 8'h80);
		wr(PM, 8'hA0);
		pulse(7'h0C);
		rdchk(PM, 8'h60);
		wr(PM, 8'h40);
		$display("test switchback done");
		wr(PM, 8'h48);
		rdchk(PM, 8'h40);
		wr(EX, 8'h00);
		step(8);
		rdchk(EX, 8'h04);
		chk(use_ring, 1'b1);
		wr(PM, 8'h48);
		rdchk(PM, 8'h48);
		chk(amp_en, 1'b0);
		rdchk(ST, 8'h00);
		wr(EX, 8'h08);
		rdchk(EX, 8'h04);
		wr(PM, 8'h40);
		t0 = cyc;
		rd = '0;
		for (int i = 0; i < 40 && rd !== 32'h00000010; i++)
			apb(1'b0, ST, 8'h00);
		chk(cyc - t0 >= 2 * WU - 4 && cyc - t0 <= 2 * WU + 12, 1'b1);
		wr(EX, 8'h08);
		step(8);
		rdchk(EX, 8'h08);
		chk(use_ring, 1'b0);
		$display("test source done");
		wr(PC, 8'h01);
		step(1);
		chk({cpu_run, clocks_on}, 2'h1);
		pulse(7'h40);
		chk(cpu_run, 1'b1);
		rdchk(PC, 8'h00);
		$display("test idle done");
		wr(PC, 8'h02);
		step(1);
		chk({clocks_on, amp_en, bg_on, sup_n}, 4'h0);
		pulse(7'h40);
		chk(clocks_on, 1'b0);
		pulse(7'h02);
		chk(clocks_on, 1'b0);
		pulse(7'h20);
		chk(cpu_run, 1'b0);
		t0 = cyc;
		for (int i = 0; i < 200 && cpu_run !== 1'b1; i++)
			@(negedge clk);
		chk(cyc - t0 >= 2 * WU - 4 && cpu_run === 1'b1, 1'b1);
		chk(use_ring, 1'b0);
		$display("test stop done");
		wr(EX, 8'h0B);
		rdchk(EX, 8'h0B);
		wr(PC, 8'h02);
		step(1);
		chk({bg_on, sup_n}, 2'h3);
		pulse(7'h01);
		chk(pf_req, 1'b1);
		pulse(7'h02);
		chk({cpu_run, use_ring}, 2'h3);
		t0 = cyc;
		rdchk(EX, 8'h0F);
		for (int i = 0; i < 200 && use_ring !== 1'b0; i++)
			@(negedge clk);
		chk(cyc - t0 >= 2 * WU - 4 && use_ring === 1'b0, 1'b1);
		$display("test ring wake done");
		print_verdict();
	end
endmodule

// Checker watches the design ports from inside each instance
bind pcm_power_clock_manager pcm_asserts chk_u (.CLK(CLK), .RST_N(RST_N), .WAKE(WAKE),
	.CYCLE_STB(CYCLE_STB), .CYCLE_DIV(CYCLE_DIV), .CPU_RUN(CPU_RUN), .CLOCKS_ON(CLOCKS_ON),
	.XTAL_AMP_EN(XTAL_AMP_EN), .BANDGAP_ON(BANDGAP_ON), .SUPPLY_RESET_OUT_N(SUPPLY_RESET_OUT_N));

`default_nettype wire
